// File: rtl/tpps_pkg.sv
/*
  package for the trace port pin select block: register offsets, field positions,
  reset values and the trace selection code.
  assumes a 32-bit AHB-Lite register bus, one aligned word per register.
*/
package tpps_pkg;

  // register byte offsets (one word each)
  localparam logic [7:0] TPPS_PA_CRH1_OFS = 8'h00;
  localparam logic [7:0] TPPS_PD_CRH1_OFS = 8'h04;
  localparam logic [7:0] TPPS_PD_CRH2_OFS = 8'h08;
  localparam logic [7:0] TPPS_PE_CRL1_OFS = 8'h0C;
  localparam logic [7:0] TPPS_PE_CRL2_OFS = 8'h10;
  localparam logic [7:0] TPPS_STATUS_OFS  = 8'h14;

  // register width and select field width
  localparam int TPPS_REG_W = 16;
  localparam int TPPS_FLD_W = 4;

  // the code that picks the trace function for a pin
  localparam logic [3:0] TPPS_SEL_TRACE = 4'h3;

  // reset value: every pin in its ordinary function
  localparam logic [15:0] TPPS_REG_RST = 16'h0000;

  // field low bit positions
  localparam int TPPS_F0 = 0;
  localparam int TPPS_F1 = 4;
  localparam int TPPS_F2 = 8;
  localparam int TPPS_F3 = 12;

  // number of trace signals per pin set (clock, four data, sync)
  localparam int TPPS_NSIG = 6;

  // status register bit positions
  localparam int TPPS_ST_PE_ACT = 0;
  localparam int TPPS_ST_PD_ACT = 6;
  localparam int TPPS_ST_PA_ACT = 12;
  localparam int TPPS_ST_DBG    = 13;

  // AHB-Lite codes
  localparam logic [1:0] TPPS_HTRANS_IDLE   = 2'b00;
  localparam logic [1:0] TPPS_HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] TPPS_HSIZE_WORD    = 3'b010;

  // trace sources as they come from the trace unit
  typedef struct packed {
    logic       clk;
    logic [3:0] data;
    logic       sync_n;
  } tpps_trace_t;

  // per-pin select flags for one pin set: clk, data0..3, sync
  typedef struct packed {
    logic       clk;
    logic [3:0] data;
    logic       sync_n;
  } tpps_sel_t;

  // AHB-Lite address phase captured for the data phase
  typedef struct packed {
    logic       write;
    logic [7:0] addr;
    logic       valid;
  } tpps_aphase_t;

endpackage : tpps_pkg

// File: rtl/tpps_pin_mux.sv
/*
  one pin's output mux: ordinary function or trace function.
  assumes the select field and both sources are on clk_i; output is registered.
*/
`timescale 1ns/100ps
module tpps_pin_mux
  import tpps_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  // select and sources
  input  wire logic [3:0] field_i,
  input  wire logic       func_out_i,
  input  wire logic       func_oe_i,
  input  wire logic       trace_i,
  // pin side
  output logic            pin_o,
  output logic            pin_oe_o,
  output logic            trace_sel_o
);

  logic sel;
  logic pin_reg;
  logic pin_next;
  logic oe_reg;
  logic oe_next;
  logic sel_reg;

  // only the exact trace code hands the pin to the trace unit
  always_comb begin
    sel      = (field_i == TPPS_SEL_TRACE);
    pin_next = sel ? trace_i : func_out_i;
    oe_next  = sel ? 1'b1 : func_oe_i;              // trace pins are outputs only
  end

  // reset leaves the pin undriven by trace logic
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_reg <= 1'b0;
      oe_reg  <= 1'b0;
      sel_reg <= 1'b0;
    end else begin
      pin_reg <= pin_next;
      oe_reg  <= oe_next;
      sel_reg <= sel;
    end
  end

  assign pin_o       = pin_reg;
  assign pin_oe_o    = oe_reg;
  assign trace_sel_o = sel_reg;

endmodule : tpps_pin_mux

// File: rtl/tpps_top.sv
/*
  trace port pin select: function-select registers for the trace pins on ports A, D
  and E, and the muxes that put the trace clock, data and sync onto either or both of two pin sets.
  assumes AHB-Lite slave access on clk_i, a power-on reset on arst_n_i and a debug
  attach level from a pin that is synchronised here.
*/
// Local design decisions: the address map and the AHB-Lite slave port.
`timescale 1ns/100ps
module tpps_top
  import tpps_pkg::*;
(
  // clock and power-on reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // debug attach level from a pin
  input  wire logic        dbg_attached_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  // trace sources
  input  wire tpps_trace_t trace_i,
  // ordinary functions: bit 0 port A pin16, 1..6 port D pins 16..19,22,23, 7..12 port E
  input  wire logic [12:0] func_out_i,
  input  wire logic [12:0] func_oe_i,
  // pins in the same order
  output logic [12:0]      pin_o,
  output logic [12:0]      pin_oe_o
);

  localparam int NPIN = 13;

  // register file
  logic [15:0]  pa_crh1_reg, pa_crh1_next;
  logic [15:0]  pd_crh1_reg, pd_crh1_next;
  logic [15:0]  pd_crh2_reg, pd_crh2_next;
  logic [15:0]  pe_crl1_reg, pe_crl1_next;
  logic [15:0]  pe_crl2_reg, pe_crl2_next;
  tpps_aphase_t ap_reg, ap_next;
  logic [31:0]  rdata_reg, rdata_next;

  // attach synchroniser and reset-catch of the attach level
  logic         dbg_meta_reg;
  logic         dbg_sync_reg;
  logic         keep_reg, keep_next;
  logic         rel_reg;

  // per-pin field, trace source, select feedback
  logic [3:0]   field [NPIN];
  logic         tsrc  [NPIN];
  logic [NPIN-1:0] tsel;

  // two flops before anyone looks at the attach pin
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dbg_meta_reg <= 1'b0;
      dbg_sync_reg <= 1'b0;
    end else begin
      dbg_meta_reg <= dbg_attached_i;
      dbg_sync_reg <= dbg_meta_reg;
    end
  end

  // the attach level is latched while running; a reset is async so it cannot
  // sample a port, so the retained copy lives in a separate register bank below
  always_comb begin
    keep_next = dbg_sync_reg;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      keep_reg <= 1'b0;
      rel_reg  <= 1'b0;
    end else begin
      keep_reg <= keep_next;
      rel_reg  <= 1'b1;
    end
  end

  // shadow copies of the trace fields, kept across reset while attached
  logic [15:0] pa_shd_reg, pd1_shd_reg, pd2_shd_reg, pe1_shd_reg, pe2_shd_reg;
  logic        shd_vld_reg;

  // shadow bank has no reset: it holds the debugger's setting across power-on
  // reset; it follows the registers only while out of reset, since the live
  // registers read zero during reset and would wipe the copy
  always_ff @(posedge clk_i) begin
    if (rel_reg) begin
      pa_shd_reg  <= pa_crh1_reg;
      pd1_shd_reg <= pd_crh1_reg;
      pd2_shd_reg <= pd_crh2_reg;
      pe1_shd_reg <= pe_crl1_reg;
      pe2_shd_reg <= pe_crl2_reg;
      shd_vld_reg <= keep_reg;
    end
  end

  // AHB-Lite: zero-wait slave, address captured in the address phase
  logic ap_take;
  logic wr_en;

  always_comb begin
    ap_take  = hsel_i && hready_i && (htrans_i == TPPS_HTRANS_NONSEQ);
    ap_next.valid = ap_take;
    ap_next.write = hwrite_i;
    ap_next.addr  = haddr_i[7:0];
    wr_en    = ap_reg.valid && ap_reg.write;
  end

  // register next values: first cycle after release restores kept fields
  always_comb begin
    pa_crh1_next = pa_crh1_reg;
    pd_crh1_next = pd_crh1_reg;
    pd_crh2_next = pd_crh2_reg;
    pe_crl1_next = pe_crl1_reg;
    pe_crl2_next = pe_crl2_reg;
    // the synchroniser is cleared by the reset itself, so the attach level
    // caught just before reset (the valid flag) decides the restore
    if (!rel_reg && shd_vld_reg) begin
      // restore these fields: port A pin16, all of port D (pins 16..23), port E 0..6
      pa_crh1_next[TPPS_F0+:TPPS_FLD_W] = pa_shd_reg[TPPS_F0+:TPPS_FLD_W];
      pd_crh1_next = pd1_shd_reg;
      pd_crh2_next = pd2_shd_reg;
      pe_crl1_next = pe1_shd_reg;
      pe_crl2_next[TPPS_F0+:3*TPPS_FLD_W] = pe2_shd_reg[TPPS_F0+:3*TPPS_FLD_W];
    end else if (wr_en) begin
      unique case (ap_reg.addr)
        TPPS_PA_CRH1_OFS: pa_crh1_next = hwdata_i[15:0];
        TPPS_PD_CRH1_OFS: pd_crh1_next = hwdata_i[15:0];
        TPPS_PD_CRH2_OFS: pd_crh2_next = hwdata_i[15:0];
        TPPS_PE_CRL1_OFS: pe_crl1_next = hwdata_i[15:0];
        TPPS_PE_CRL2_OFS: pe_crl2_next = hwdata_i[15:0];
        default: ;                                         // unmapped writes dropped
      endcase
    end
  end

  // read data for the next data phase
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (ap_take && !hwrite_i) begin
      unique case (haddr_i[7:0])
        TPPS_PA_CRH1_OFS: rdata_next = {16'h0000, pa_crh1_reg};
        TPPS_PD_CRH1_OFS: rdata_next = {16'h0000, pd_crh1_reg};
        TPPS_PD_CRH2_OFS: rdata_next = {16'h0000, pd_crh2_reg};
        TPPS_PE_CRL1_OFS: rdata_next = {16'h0000, pe_crl1_reg};
        TPPS_PE_CRL2_OFS: rdata_next = {16'h0000, pe_crl2_reg};
        TPPS_STATUS_OFS: begin
          rdata_next[TPPS_ST_PA_ACT]    = tsel[0];
          rdata_next[TPPS_ST_PD_ACT+:TPPS_NSIG] = tsel[6:1];
          rdata_next[TPPS_ST_PE_ACT+:TPPS_NSIG] = tsel[12:7];
          rdata_next[TPPS_ST_DBG]       = dbg_sync_reg;
        end
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // all fields reset to ordinary function
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pa_crh1_reg <= TPPS_REG_RST;
      pd_crh1_reg <= TPPS_REG_RST;
      pd_crh2_reg <= TPPS_REG_RST;
      pe_crl1_reg <= TPPS_REG_RST;
      pe_crl2_reg <= TPPS_REG_RST;
      ap_reg      <= '0;
      rdata_reg   <= 32'h0000_0000;
    end else begin
      pa_crh1_reg <= pa_crh1_next;
      pd_crh1_reg <= pd_crh1_next;
      pd_crh2_reg <= pd_crh2_next;
      pe_crl1_reg <= pe_crl1_next;
      pe_crl2_reg <= pe_crl2_next;
      ap_reg      <= ap_next;
      rdata_reg   <= rdata_next;
    end
  end

  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = rdata_reg;

  // pin field and trace source map; each signal appears on two pins
  always_comb begin
    field[0]  = pa_crh1_reg[TPPS_F0+:TPPS_FLD_W]; tsrc[0]  = trace_i.sync_n;
    field[1]  = pd_crh1_reg[TPPS_F0+:TPPS_FLD_W]; tsrc[1]  = trace_i.data[0];
    field[2]  = pd_crh1_reg[TPPS_F1+:TPPS_FLD_W]; tsrc[2]  = trace_i.data[1];
    field[3]  = pd_crh1_reg[TPPS_F2+:TPPS_FLD_W]; tsrc[3]  = trace_i.data[2];
    field[4]  = pd_crh1_reg[TPPS_F3+:TPPS_FLD_W]; tsrc[4]  = trace_i.data[3];
    field[5]  = pd_crh2_reg[TPPS_F2+:TPPS_FLD_W]; tsrc[5]  = trace_i.clk;
    field[6]  = pd_crh2_reg[TPPS_F3+:TPPS_FLD_W]; tsrc[6]  = trace_i.sync_n;
    field[7]  = pe_crl1_reg[TPPS_F0+:TPPS_FLD_W]; tsrc[7]  = trace_i.clk;
    field[8]  = pe_crl1_reg[TPPS_F3+:TPPS_FLD_W]; tsrc[8]  = trace_i.data[3];
    field[9]  = pe_crl2_reg[TPPS_F0+:TPPS_FLD_W]; tsrc[9]  = trace_i.data[2];
    field[10] = pe_crl2_reg[TPPS_F1+:TPPS_FLD_W]; tsrc[10] = trace_i.data[1];
    field[11] = pe_crl2_reg[TPPS_F2+:TPPS_FLD_W]; tsrc[11] = trace_i.data[0];
    field[12] = 4'h0;                             tsrc[12] = 1'b0;            // spare, ordinary
  end

  // one registered mux per pin; ordinary function unless trace code is set
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_pin
      tpps_pin_mux u_mux (
        .clk_i      (clk_i),
        .arst_n_i   (arst_n_i),
        .field_i    (field[g]),
        .func_out_i (func_out_i[g]),
        .func_oe_i  (func_oe_i[g]),
        .trace_i    (tsrc[g]),
        .pin_o      (pin_o[g]),
        .pin_oe_o   (pin_oe_o[g]),
        .trace_sel_o(tsel[g])
      );
    end
  endgenerate

endmodule : tpps_top

// File: dv/tpps_top_props.sv
/* checker for the trace pin select: bus answer, read-back and pin relations.
   assumes it is bound to tpps_top and the attach level is steady around resets. */
`timescale 1ns/100ps
module tpps_top_props
  import tpps_pkg::*;
(
  // clock, reset and attach level
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  input wire logic        dbg_attached_i,
  // register bus
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic        hready_i,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic [31:0] hrdata_o,
  // sources and pins
  input wire tpps_trace_t trace_i,
  input wire logic [12:0] func_out_i,
  input wire logic [12:0] func_oe_i,
  input wire logic [12:0] pin_o,
  input wire logic [12:0] pin_oe_o
);
  logic [15:0] sh_reg [5];
  logic [7:0]  a_reg;
  logic        wp_reg, rp_reg, take;
  logic [1:0]  up_reg;
  logic [12:0] sel, tv, ev, eo;
  logic [31:0] erd;

  function automatic logic on(input logic [3:0] f);
    return f == TPPS_SEL_TRACE;
  endfunction : on

  // expected select, value and enable per pin, pin 12 down to pin 0
  assign take = hsel_i & hready_i & (htrans_i == TPPS_HTRANS_NONSEQ);
  assign sel  = {1'b0, on(sh_reg[4][11:8]), on(sh_reg[4][7:4]), on(sh_reg[4][3:0]),
                 on(sh_reg[3][15:12]), on(sh_reg[3][3:0]), on(sh_reg[2][15:12]),
                 on(sh_reg[2][11:8]), on(sh_reg[1][15:12]), on(sh_reg[1][11:8]),
                 on(sh_reg[1][7:4]), on(sh_reg[1][3:0]), on(sh_reg[0][3:0])};
  assign tv   = {1'b0, trace_i.data[0], trace_i.data[1], trace_i.data[2], trace_i.data[3],
                 trace_i.clk, trace_i.sync_n, trace_i.clk, trace_i.data, trace_i.sync_n};
  assign ev   = (sel & tv) | (~sel & func_out_i);
  assign eo   = sel | func_oe_i;
  assign erd  = (a_reg < TPPS_STATUS_OFS) ? {16'h0000, sh_reg[a_reg[4:2]]} : 32'h0000_0000;

  // the shadow keeps its fields through a reset while the debugger is attached
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wp_reg <= 1'b0;
      rp_reg <= 1'b0;
      up_reg <= 2'd0;
      if (!dbg_attached_i) sh_reg <= '{default: TPPS_REG_RST};
    end else begin
      wp_reg <= take & hwrite_i;
      rp_reg <= take & ~hwrite_i;
      a_reg  <= haddr_i[7:0];
      if (up_reg != 2'd3) up_reg <= up_reg + 2'd1;
      if (wp_reg && a_reg < TPPS_STATUS_OFS) sh_reg[a_reg[4:2]] <= hwdata_i[15:0];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  a_ready_high: assert property (hreadyout_o == 1'b1)
    else $error("bus ready dropped");
  a_resp_okay: assert property (take |=> hresp_o == 1'b0)
    else $error("bus response not okay");
  a_read_back: assert property (rp_reg && a_reg != TPPS_STATUS_OFS |-> hrdata_o == erd)
    else $error("read data differs from written field");
  a_reset_plain: assert property (up_reg inside {2'd1, 2'd2} && !dbg_attached_i |->
    pin_o == $past(func_out_i) && pin_oe_o == $past(func_oe_i))
    else $error("pin not ordinary after reset");
  a_attach_kept: assert property (up_reg == 2'd2 && dbg_attached_i |->
    pin_o == $past(ev) && pin_oe_o == $past(eo))
    else $error("select lost over attached reset");
  a_pin_value: assert property (up_reg == 2'd3 |-> pin_o == $past(ev))
    else $error("pin value wrong for its select");
  a_pin_enable: assert property (up_reg == 2'd3 |-> pin_oe_o == $past(eo))
    else $error("pin enable wrong for its select");
  a_spare_plain: assert property (up_reg != 2'd0 |-> pin_o[12] == $past(func_out_i[12]))
    else $error("spare pin left ordinary function");

  c_trace_on: cover property (sel[7] && sel[0]);
  c_kept: cover property (up_reg == 2'd2 && dbg_attached_i);
  c_read: cover property (rp_reg && sh_reg[1] != 16'h0000);
endmodule : tpps_top_props

bind tpps_top tpps_top_props u_props (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .dbg_attached_i(dbg_attached_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .hrdata_o(hrdata_o), .trace_i(trace_i), .func_out_i(func_out_i),
  .func_oe_i(func_oe_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o));

// File: dv/tpps_dbg_host.sv
/* behavioural model of the debug host capturing trace at its connector.
   assumes the host only listens and is wired to one pin set at a time. */
`timescale 1ns/100ps
module tpps_dbg_host
  import tpps_pkg::*;
(
  // which alternative pin set reaches the connector
  input  wire logic        use_pe_i,
  // device pins
  input  wire logic [12:0] pin_i,
  input  wire logic [12:0] pin_oe_i,
  // captured trace, and all wired pins driven
  output tpps_trace_t      cap_o,
  output logic             wired_o
);
  // host never drives, so the unwired set stays free for its ordinary use
  always_comb begin
    if (use_pe_i) begin
      cap_o   = {pin_i[7], pin_i[8], pin_i[9], pin_i[10], pin_i[11], pin_i[0]};
      wired_o = &{pin_oe_i[11:7], pin_oe_i[0]};
    end else begin
      cap_o   = {pin_i[5], pin_i[4], pin_i[3], pin_i[2], pin_i[1], pin_i[6]};
      wired_o = &pin_oe_i[6:1];
    end
  end
endmodule : tpps_dbg_host

// File: dv/tb.sv
/* self-checking bench for the trace pin select: bus tasks, moving sources, scenarios.
   assumes a single slave whose ready is the bus ready; no wait count is assumed. */
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module tb
  import tpps_pkg::*;
;
  logic        clk_i, arst_n_i, dbg_i, use_pe, wired, hwrite_i, hreadyout_o, hresp_o;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, r;
  logic [1:0]  htrans_i;
  logic [12:0] fo, foe, pin_o, pin_oe_o, prev_fo, prev_oe;
  logic [15:0] pat;
  tpps_trace_t tr, prev_tr, cap;
  int          n_errors, n_tests;

  tpps_top uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .dbg_attached_i(dbg_i), .hsel_i(1'b1),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(TPPS_HSIZE_WORD),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .hrdata_o(hrdata_o), .trace_i(tr), .func_out_i(fo), .func_oe_i(foe), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o));
  tpps_dbg_host u_host (.use_pe_i(use_pe), .pin_i(pin_o), .pin_oe_i(pin_oe_o), .cap_o(cap),
    .wired_o(wired));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // sources move every cycle so a stuck mux cannot hide
  always @(posedge clk_i) begin
    pat     <= pat + 16'h0025;
    tr      <= tpps_trace_t'(pat[5:0] ^ pat[11:6]);
    fo      <= ~pat[12:0];
    foe     <= pat[15:3];
    prev_tr <= tr;
    prev_fo <= fo;
    prev_oe <= foe;
  end

  task automatic results;
    if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  // one transfer; ready and read data are sampled just before the edge they belong to
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int   k;
    logic rdy;
    @(posedge clk_i);
    haddr_i  <= {24'h00_0000, a};
    htrans_i <= TPPS_HTRANS_NONSEQ;
    hwrite_i <= w;
    for (int p = 0; p < 2; p++) begin
      k = 0;
      do begin
        @(negedge clk_i);
        rdy = hreadyout_o;
        r   = hrdata_o;
        @(posedge clk_i);
        k++;
      end while (rdy !== 1'b1 && k < 20);
      if (rdy !== 1'b1) begin
        n_errors++;
        results();
      end
      htrans_i <= TPPS_HTRANS_IDLE;
      hwdata_i <= d;
    end
  endtask : bus

  function automatic logic [25:0] exp_pins(input logic [12:0] s);
    logic [12:0] tv;
    tv = {1'b0, prev_tr.data[0], prev_tr.data[1], prev_tr.data[2], prev_tr.data[3],
          prev_tr.clk, prev_tr.sync_n, prev_tr.clk, prev_tr.data, prev_tr.sync_n};
    return {s | prev_oe, (s & tv) | (~s & prev_fo)};
  endfunction : exp_pins

  // a select lands one edge after its write and shows on the pins one edge later
  task automatic chk_pins(input logic [12:0] s);
    repeat (2) @(negedge clk_i);
    `CHK({pin_oe_o, pin_o}, exp_pins(s))
  endtask : chk_pins

  task automatic rst_pulse;
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask : rst_pulse

  task automatic t_defaults;
    chk_pins(13'h0000);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, 8'(4 * i), '0);
      `CHK(r, 32'h0000_0000)
    end
    bus(1'b1, 8'h18, 32'hFFFF_FFFF);
    bus(1'b0, 8'h18, '0);
    `CHK(r, 32'h0000_0000)
  endtask : t_defaults

  task automatic t_port_e;
    use_pe = 1'b1;
    bus(1'b1, TPPS_PA_CRH1_OFS, 32'h0000_0003);
    bus(1'b1, TPPS_PE_CRL1_OFS, 32'hFFFF_3003);
    bus(1'b1, TPPS_PE_CRL2_OFS, 32'h0000_0333);
    chk_pins(13'h0F81);
    `CHK({wired, cap}, {1'b1, prev_tr})
    bus(1'b0, TPPS_PE_CRL1_OFS, '0);
    `CHK(r, 32'h0000_3003)
  endtask : t_port_e

  task automatic t_port_ad;
    use_pe = 1'b0;
    bus(1'b1, TPPS_PE_CRL2_OFS, '0);
    bus(1'b1, TPPS_PA_CRH1_OFS, 32'h0000_0003);
    bus(1'b1, TPPS_PD_CRH1_OFS, 32'h0000_3333);
    bus(1'b1, TPPS_PD_CRH2_OFS, 32'h0000_3300);
    chk_pins(13'h01FF);
    `CHK({wired, cap}, {1'b1, prev_tr})
    bus(1'b0, TPPS_PD_CRH2_OFS, '0);
    `CHK(r, 32'h0000_3300)
  endtask : t_port_ad

  task automatic t_codes;
    for (int c = 0; c < 16; c++) begin
      bus(1'b1, TPPS_PE_CRL1_OFS, 32'(c));
      chk_pins((c == 3) ? 13'h00FF : 13'h007F);
    end
  endtask : t_codes

  task automatic t_attach;
    bus(1'b1, TPPS_PE_CRL1_OFS, 32'h0000_3003);
    bus(1'b1, TPPS_PE_CRL2_OFS, 32'h0000_0333);
    dbg_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_pulse();
    chk_pins(13'h0FFF);
    bus(1'b0, TPPS_PA_CRH1_OFS, '0);
    `CHK(r, 32'h0000_0003)
    dbg_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rst_pulse();
    chk_pins(13'h0000);
    bus(1'b0, TPPS_PD_CRH1_OFS, '0);
    `CHK(r, 32'h0000_0000)
  endtask : t_attach

  initial begin
    {arst_n_i, dbg_i, hwrite_i, use_pe, haddr_i, hwdata_i, htrans_i, tr, fo, foe, pat} = '0;
    n_errors = 0;
    n_tests  = 0;
    rst_pulse();
    t_defaults();
    t_port_e();
    t_port_ad();
    t_codes();
    t_attach();
    results();
  end
endmodule : tb
